// ==== rtl/hpc_pkg.sv ====
// Purpose: shared constants and types of the host port control and pointer block
// Assumes: 32-bit processor-side register words, 16-bit host-side halfwords
// Notes:   bit positions are those of the control word seen by both parties
package hpc_pkg;

    // processor-side byte offsets
    localparam logic [7:0]  CONTROL_OFFSET       = 8'h30;
    localparam logic [7:0]  WRITE_POINTER_OFFSET = 8'h34;
    localparam logic [7:0]  READ_POINTER_OFFSET  = 8'h38;

    // control word field positions
    localparam int          POINTER_SELECT_BIT   = 11;
    localparam int          SPLIT_MODE_BIT       = 9;
    localparam int          HALF_STATUS_BIT      = 8;
    localparam int          SOFT_RESET_BIT       = 7;
    localparam int          FETCH_BIT            = 4;
    localparam int          FIXED_ONE_BIT        = 3;
    localparam int          HOST_INTERRUPT_BIT   = 2;
    localparam int          CPU_INTERRUPT_BIT    = 1;
    localparam int          HALF_ORDER_BIT       = 0;

    // reset values
    localparam logic [31:0] POINTER_RESET        = 32'h0000_8000;
    localparam logic        CONFIG_RESET         = 1'b0;
    localparam logic        FIXED_ONE_VALUE      = 1'b1;

    // what a host access is aimed at
    typedef enum logic {
        HPC_HOST_CONTROL,
        HPC_HOST_POINTER
    } hpc_host_target_type;

endpackage : hpc_pkg

// ==== rtl/hpc_flag.sv ====
// Purpose: one control flag driven to an active level by one party, back by another
// Assumes: both strobes come from logic on the same clock
// Notes:   the activating strobe wins when both arrive together
module hpc_flag #(
    parameter logic ACTIVE = 1'b1
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic activate,
    input  wire logic release_,
    output logic      level
);

    // activation beats release so no event is lost
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            level <= ~ACTIVE;
        end else if (activate) begin
            level <= ACTIVE;
        end else if (release_) begin
            level <= ~ACTIVE;
        end
    end

endmodule : hpc_flag

// ==== rtl/hpc_pointer_reg.sv ====
// Purpose: one 32-bit address pointer with independent halfword write enables
// Assumes: a full-word write raises both enables
// Notes:   the reset value is given by the instantiating module
module hpc_pointer_reg #(
    parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        writeHigh,
    input  wire logic        writeLow,
    input  wire logic [31:0] writeData,
    output logic      [31:0] pointer
);

    // upper halfword
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pointer[31:16] <= RESET_VALUE[31:16];
        end else if (writeHigh) begin
            pointer[31:16] <= writeData[31:16];
        end
    end

    // lower halfword
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pointer[15:0] <= RESET_VALUE[15:0];
        end else if (writeLow) begin
            pointer[15:0] <= writeData[15:0];
        end
    end

endmodule : hpc_pointer_reg

// ==== rtl/hpc_control_pointers.sv ====
// Purpose: control word and read/write address pointers shared by host and processor
// Assumes: host and processor strobes come from logic on this clock, one cycle each
// Notes:   read data appear one cycle after the read strobe and hold until the next read

// Notes on behaviour
// - in split mode, pointer select 0 picks the write pointer, 1 the read pointer
// - split mode clear makes both pointers one for the host; set separates them
// - processor always reads each pointer, writes it only while it owns pointers; split implied while it owns pointers
// - half order status bit always mirrors half order, updated by the same write
// - host writing 1 to fetch posts a prefetch request; processor writes ignored
// - fetch bit always reads zero for both parties
// - processor writing 1 to host interrupt bit drives the host pin low
// - host clears a pending host interrupt by writing 1; pin returns high
// - host interrupt bit reads as inverse of the host pin level
// - writing 0 to host interrupt bit changes neither bit nor pin
// - host writing 1 raises processor interrupt; zero writes do nothing
// - half order governs data and pointer halfwords; 0 means first is upper
// - two 32-bit pointers, each reset to 8000h in the lower half
// - non-owner of control may only write 1 to interrupt, fetch and soft reset bits
// - control owner is host when 0, processor when 1 if it owns pointers
// - pointer owner is host when 0, processor when 1
module hpc_control_pointers (
    input  wire logic                         clock,
    input  wire logic                         rst_b,
    // ownership from the system-level control
    input  wire logic                         controlWriteOwner,
    input  wire logic                         pointerWriteOwner,
    // host halfword port
    input  wire logic                         hostSel,
    input  wire logic                         hostWrite,
    input  wire hpc_pkg::hpc_host_target_type hostTarget,
    input  wire logic                         hostHalf,
    input  wire logic [15:0]                  hostWdata,
    output logic      [15:0]                  hostRdata,
    // processor word port
    input  wire logic                         cpuSel,
    input  wire logic                         cpuWrite,
    input  wire logic [7:0]                   cpuAddr,
    input  wire logic [31:0]                  cpuWdata,
    output logic      [31:0]                  cpuRdata,
    // block outputs
    output logic                              hostInterruptPin_b,
    output logic                              processorInterruptRequest,
    output logic                              prefetchRequest,
    output logic                              portSoftReset,
    output logic                              halfOrder,
    output logic                              splitPointerMode,
    output logic                              pointerSelect,
    output logic      [31:0]                  writePointer,
    output logic      [31:0]                  readPointer
);
    import hpc_pkg::*;

    logic        halfOrderStatus;
    logic        hostWr;
    logic        hostRd;
    logic        hostUpper;
    logic        hostCtlWr;
    logic        hostPtrWr;
    logic        cpuWr;
    logic        cpuRd;
    logic        cpuCtlWr;
    logic        cpuWpWr;
    logic        cpuRpWr;
    logic        cpuOwnsCtl;
    logic        cpuOwnsPtr;
    logic        effSplit;
    logic        hostToWrite;
    logic        hostToRead;
    logic        ownerWr;
    logic [31:0] ownerData;
    logic [31:0] hostPtrData;
    logic [31:0] hostPtrView;
    logic [31:0] ctlValue;

    // access decode per port
    assign hostWr    = hostSel & hostWrite;
    assign hostRd    = hostSel & ~hostWrite;
    assign cpuWr     = cpuSel & cpuWrite;
    assign cpuRd     = cpuSel & ~cpuWrite;
    // first halfword is the upper one when half order is 0
    assign hostUpper = ~(hostHalf ^ halfOrder);
    assign hostCtlWr = hostWr & (hostTarget == HPC_HOST_CONTROL) & ~hostUpper;
    assign cpuCtlWr  = cpuWr & (cpuAddr == CONTROL_OFFSET);

    // ownership of control word and pointers
    assign cpuOwnsPtr = pointerWriteOwner;
    assign cpuOwnsCtl = controlWriteOwner & pointerWriteOwner;
    assign ownerWr    = cpuOwnsCtl ? cpuCtlWr : hostCtlWr;
    assign ownerData  = cpuOwnsCtl ? cpuWdata : {16'h0000, hostWdata};

    // pointer routing for the host
    assign effSplit    = splitPointerMode | cpuOwnsPtr;
    assign hostToWrite = effSplit ? ~pointerSelect : 1'b1;
    assign hostToRead  = effSplit ? pointerSelect : 1'b1;
    assign hostPtrWr   = hostWr & (hostTarget == HPC_HOST_POINTER) & ~cpuOwnsPtr;
    assign hostPtrData = {hostWdata, hostWdata};
    assign hostPtrView = (effSplit & pointerSelect) ? readPointer : writePointer;
    assign cpuWpWr     = cpuWr & (cpuAddr == WRITE_POINTER_OFFSET) & cpuOwnsPtr;
    assign cpuRpWr     = cpuWr & (cpuAddr == READ_POINTER_OFFSET) & cpuOwnsPtr;

    // configuration fields, written by the owner only
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pointerSelect    <= CONFIG_RESET;
            splitPointerMode <= CONFIG_RESET;
            halfOrder        <= CONFIG_RESET;
            halfOrderStatus  <= CONFIG_RESET;
        end else if (ownerWr) begin
            pointerSelect    <= ownerData[POINTER_SELECT_BIT];
            splitPointerMode <= ownerData[SPLIT_MODE_BIT];
            halfOrder        <= ownerData[HALF_ORDER_BIT];
            halfOrderStatus  <= ownerData[HALF_ORDER_BIT];
        end
    end

    // prefetch request, one cycle per host write of 1
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prefetchRequest <= 1'b0;
        end else begin
            prefetchRequest <= hostCtlWr & hostWdata[FETCH_BIT];
        end
    end

    // host pin: processor drives low, host releases high
    hpc_flag #(
        .ACTIVE   (1'b0)
    ) u_host_interrupt (
        .clock    (clock),
        .rst_b    (rst_b),
        .activate (cpuCtlWr & cpuWdata[HOST_INTERRUPT_BIT]),
        .release_ (hostCtlWr & hostWdata[HOST_INTERRUPT_BIT]),
        .level    (hostInterruptPin_b)
    );

    // processor interrupt: host raises, processor clears by writing 1
    hpc_flag #(
        .ACTIVE   (1'b1)
    ) u_cpu_interrupt (
        .clock    (clock),
        .rst_b    (rst_b),
        .activate (hostCtlWr & hostWdata[CPU_INTERRUPT_BIT]),
        .release_ (cpuCtlWr & cpuWdata[CPU_INTERRUPT_BIT]),
        .level    (processorInterruptRequest)
    );

    // soft reset: either party sets by 1, owner clears by 0
    hpc_flag #(
        .ACTIVE   (1'b1)
    ) u_soft_reset (
        .clock    (clock),
        .rst_b    (rst_b),
        .activate ((hostCtlWr & hostWdata[SOFT_RESET_BIT]) |
                   (cpuCtlWr & cpuWdata[SOFT_RESET_BIT])),
        .release_ (ownerWr & ~ownerData[SOFT_RESET_BIT]),
        .level    (portSoftReset)
    );

    // write pointer: host halfwords or processor words
    hpc_pointer_reg #(
        .RESET_VALUE (POINTER_RESET)
    ) u_write_pointer (
        .clock     (clock),
        .rst_b     (rst_b),
        .writeHigh ((hostPtrWr & hostToWrite & hostUpper) | cpuWpWr),
        .writeLow  ((hostPtrWr & hostToWrite & ~hostUpper) | cpuWpWr),
        .writeData (cpuWpWr ? cpuWdata : hostPtrData),
        .pointer   (writePointer)
    );

    // read pointer: shared with the write pointer unless split
    hpc_pointer_reg #(
        .RESET_VALUE (POINTER_RESET)
    ) u_read_pointer (
        .clock     (clock),
        .rst_b     (rst_b),
        .writeHigh ((hostPtrWr & hostToRead & hostUpper) | cpuRpWr),
        .writeLow  ((hostPtrWr & hostToRead & ~hostUpper) | cpuRpWr),
        .writeData (cpuRpWr ? cpuWdata : hostPtrData),
        .pointer   (readPointer)
    );

    // control word as read by either party
    always_comb begin
        ctlValue                     = 32'h0000_0000;
        ctlValue[POINTER_SELECT_BIT] = pointerSelect;
        ctlValue[SPLIT_MODE_BIT]     = splitPointerMode;
        ctlValue[HALF_STATUS_BIT]    = halfOrderStatus;
        ctlValue[SOFT_RESET_BIT]     = portSoftReset;
        ctlValue[FETCH_BIT]          = 1'b0;
        ctlValue[FIXED_ONE_BIT]      = FIXED_ONE_VALUE;
        ctlValue[HOST_INTERRUPT_BIT] = ~hostInterruptPin_b;
        ctlValue[CPU_INTERRUPT_BIT]  = processorInterruptRequest;
        ctlValue[HALF_ORDER_BIT]     = halfOrder;
    end

    // host read data, halfword picked by the ordering bit
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hostRdata <= 16'h0000;
        end else if (hostRd) begin
            if (hostTarget == HPC_HOST_CONTROL) begin
                hostRdata <= hostUpper ? ctlValue[31:16] : ctlValue[15:0];
            end else begin
                hostRdata <= hostUpper ? hostPtrView[31:16] : hostPtrView[15:0];
            end
        end
    end

    // processor read data, unmapped offsets read zero
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cpuRdata <= 32'h0000_0000;
        end else if (cpuRd) begin
            unique case (cpuAddr)
                CONTROL_OFFSET:       cpuRdata <= ctlValue;
                WRITE_POINTER_OFFSET: cpuRdata <= writePointer;
                READ_POINTER_OFFSET:  cpuRdata <= readPointer;
                default:              cpuRdata <= 32'h0000_0000;
            endcase
        end
    end

    // checks on routing, pointers, control bits, interrupts and ownership
    a_select_route: assert property (@(posedge clock) disable iff (!rst_b)
        (hostPtrWr && splitPointerMode && pointerSelect) |=> $stable(writePointer))
        else $error("split select 1 still wrote the write pointer");

    a_shared_pointer: assert property (@(posedge clock) disable iff (!rst_b)
        (hostPtrWr && !effSplit && hostUpper)
        |=> (writePointer[31:16] == $past(hostWdata)) && (readPointer[31:16] == $past(hostWdata)))
        else $error("single mode host write did not reach both pointers");

    a_cpu_pointer: assert property (@(posedge clock) disable iff (!rst_b)
        cpuWpWr |=> (writePointer == $past(cpuWdata)) && $stable(readPointer))
        else $error("processor write pointer access not individual");

    a_status_mirror: assert property (@(posedge clock) disable iff (!rst_b)
        ownerWr |=> (halfOrderStatus == halfOrder) && (halfOrder == $past(ownerData[0])))
        else $error("half order status out of step");

    a_fetch_request: assert property (@(posedge clock) disable iff (!rst_b)
        (hostCtlWr && hostWdata[FETCH_BIT]) |=> prefetchRequest)
        else $error("host fetch write gave no prefetch request");

    a_fetch_cpu_ignored: assert property (@(posedge clock) disable iff (!rst_b)
        (cpuCtlWr && !hostCtlWr) |=> !prefetchRequest)
        else $error("processor write posted a prefetch");

    a_fetch_reads_zero: assert property (@(posedge clock) disable iff (!rst_b)
        (cpuRd && cpuAddr == CONTROL_OFFSET) |=> !cpuRdata[FETCH_BIT])
        else $error("fetch bit read as one");

    a_host_interrupt_pin_assert: assert property (@(posedge clock) disable iff (!rst_b)
        (cpuCtlWr && cpuWdata[HOST_INTERRUPT_BIT]) |=> !hostInterruptPin_b)
        else $error("host pin not driven low");

    a_host_interrupt_pin_clear: assert property (@(posedge clock) disable iff (!rst_b)
        (hostCtlWr && hostWdata[HOST_INTERRUPT_BIT]
         && !(cpuCtlWr && cpuWdata[HOST_INTERRUPT_BIT])) |=> hostInterruptPin_b)
        else $error("host pin not released");

    a_host_interrupt_pin_readback: assert property (@(posedge clock) disable iff (!rst_b)
        (cpuRd && cpuAddr == CONTROL_OFFSET)
        |=> cpuRdata[HOST_INTERRUPT_BIT] == !$past(hostInterruptPin_b))
        else $error("host interrupt bit not inverse of pin");

    a_host_interrupt_pin_zero_write: assert property (@(posedge clock) disable iff (!rst_b)
        ((hostCtlWr || cpuCtlWr) && !(hostCtlWr && hostWdata[HOST_INTERRUPT_BIT])
         && !(cpuCtlWr && cpuWdata[HOST_INTERRUPT_BIT])) |=> $stable(hostInterruptPin_b))
        else $error("zero write moved the host pin");

    a_cpu_interrupt: assert property (@(posedge clock) disable iff (!rst_b)
        (hostCtlWr && hostWdata[CPU_INTERRUPT_BIT]) |=> processorInterruptRequest)
        else $error("host write did not raise processor interrupt");

    a_pointer_reset: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(rst_b) |-> (writePointer == POINTER_RESET) && (readPointer == POINTER_RESET))
        else $error("pointer reset value wrong");

    a_nonowner_locked: assert property (@(posedge clock) disable iff (!rst_b)
        (cpuCtlWr && !cpuOwnsCtl && !hostCtlWr)
        |=> $stable(splitPointerMode) && $stable(pointerSelect) && $stable(halfOrder))
        else $error("non-owner changed configuration");

    a_control_owner: assert property (@(posedge clock) disable iff (!rst_b)
        (cpuCtlWr && cpuOwnsCtl) |=> splitPointerMode == $past(cpuWdata[SPLIT_MODE_BIT]))
        else $error("owning processor write not applied");

    a_pointer_owner: assert property (@(posedge clock) disable iff (!rst_b)
        (hostWr && hostTarget == HPC_HOST_POINTER && pointerWriteOwner)
        |=> $stable(writePointer) && $stable(readPointer))
        else $error("host wrote pointers it does not own");

    a_soft_reset_set: assert property (@(posedge clock) disable iff (!rst_b)
        (cpuCtlWr && cpuWdata[SOFT_RESET_BIT]) |=> portSoftReset)
        else $error("processor soft reset write not taken");

endmodule : hpc_control_pointers

// ==== verif/hpc_host_model.sv ====
// Purpose: behavioural external host issuing halfword accesses to the control block
// Assumes: one access at a time, strobe high for exactly one clock, driven at the rising edge
// Notes:   write data is inverted after each transfer so stale values never look valid
module hpc_host_model
    import hpc_pkg::*;
(
    input  wire logic                     clock,
    output logic                          hostSel,
    output logic                          hostWrite,
    output hpc_pkg::hpc_host_target_type  hostTarget,
    output logic                          hostHalf,
    output logic [15:0]                   hostWdata,
    input  wire logic [15:0]              hostRdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle host: no strobe, data lines carry a pattern
    initial begin
        hostSel    = 1'b0;
        hostWrite  = 1'b0;
        hostTarget = HPC_HOST_CONTROL;
        hostHalf   = 1'b0;
        hostWdata  = 16'hA5A5;
    end

    // one halfword write; reserved control bits 10, 6 and 5 go out as zero, bits 15 to 12 pass unchanged
    task automatic host_write(input hpc_host_target_type tgt, input logic half,
                              input logic [15:0] data);
        @(posedge clock);
        hostSel    <= 1'b1;
        hostWrite  <= 1'b1;
        hostTarget <= tgt;
        hostHalf   <= half;
        hostWdata  <= (tgt == HPC_HOST_CONTROL) ? (data & 16'hFB9F) : data;
        @(posedge clock);
        hostSel    <= 1'b0;
        hostWdata  <= ~data;
    endtask : host_write

    // one halfword read; data taken once the registered answer has settled
    task automatic host_read(input hpc_host_target_type tgt, input logic half,
                             output logic [15:0] data);
        @(posedge clock);
        hostSel    <= 1'b1;
        hostWrite  <= 1'b0;
        hostTarget <= tgt;
        hostHalf   <= half;
        @(posedge clock);
        hostSel    <= 1'b0;
        @(posedge clock);
        @(negedge clock);
        data = hostRdata;
    endtask : host_read

endmodule : hpc_host_model

// ==== verif/hpc_control_pointers_tb.sv ====
// Purpose: self-checking bench of the control word and pointer block
// Assumes: host side driven by the host model, processor side by local tasks
// Notes:   expectations are worked out from bit positions, never read back from the design
`define CHECK_EQ(got, exp) \
    begin \
        nChecks++; \
        if ((got) !== (exp)) begin \
            nMismatch++; \
            $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module hpc_control_pointers_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hpc_pkg::*;

    logic                clock = 1'b0;
    logic                rst_b = 1'b0;
    logic                controlWriteOwner = 1'b0;
    logic                pointerWriteOwner = 1'b0;
    logic                hostSel;
    logic                hostWrite;
    hpc_host_target_type hostTarget;
    logic                hostHalf;
    logic [15:0]         hostWdata;
    logic [15:0]         hostRdata;
    logic                cpuSel = 1'b0;
    logic                cpuWrite = 1'b0;
    logic [7:0]          cpuAddr = 8'h00;
    logic [31:0]         cpuWdata = 32'h0000_0000;
    logic [31:0]         cpuRdata;
    logic                hostInterruptPin_b;
    logic                processorInterruptRequest;
    logic                prefetchRequest;
    logic                portSoftReset;
    logic                halfOrder;
    logic                splitPointerMode;
    logic                pointerSelect;
    logic [31:0]         writePointer;
    logic [31:0]         readPointer;
    logic [31:0]         w;
    logic [15:0]         h;
    int                  nChecks = 0;
    int                  nMismatch = 0;

    // 25 MHz clock
    always #20 clock = ~clock;

    hpc_control_pointers i_hpc_control_pointers (
        .clock(clock), .rst_b(rst_b), .controlWriteOwner(controlWriteOwner),
        .pointerWriteOwner(pointerWriteOwner), .hostSel(hostSel), .hostWrite(hostWrite),
        .hostTarget(hostTarget), .hostHalf(hostHalf), .hostWdata(hostWdata),
        .hostRdata(hostRdata), .cpuSel(cpuSel), .cpuWrite(cpuWrite), .cpuAddr(cpuAddr),
        .cpuWdata(cpuWdata), .cpuRdata(cpuRdata), .hostInterruptPin_b(hostInterruptPin_b),
        .processorInterruptRequest(processorInterruptRequest),
        .prefetchRequest(prefetchRequest), .portSoftReset(portSoftReset), .halfOrder(halfOrder),
        .splitPointerMode(splitPointerMode), .pointerSelect(pointerSelect),
        .writePointer(writePointer), .readPointer(readPointer)
    );

    hpc_host_model i_hpc_host_model (
        .clock(clock), .hostSel(hostSel), .hostWrite(hostWrite), .hostTarget(hostTarget),
        .hostHalf(hostHalf), .hostWdata(hostWdata), .hostRdata(hostRdata)
    );

    // processor word accesses, strobe high for one clock
    task automatic cpu_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clock);
        cpuSel   <= 1'b1;
        cpuWrite <= 1'b1;
        cpuAddr  <= addr;
        cpuWdata <= data;
        @(posedge clock);
        cpuSel   <= 1'b0;
        cpuWdata <= ~data;
    endtask : cpu_write

    task automatic cpu_read(input logic [7:0] addr, output logic [31:0] data);
        @(posedge clock);
        cpuSel   <= 1'b1;
        cpuWrite <= 1'b0;
        cpuAddr  <= addr;
        @(posedge clock);
        cpuSel   <= 1'b0;
        @(posedge clock);
        @(negedge clock);
        data = cpuRdata;
    endtask : cpu_read

    // counts, verdict and end of run
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", nChecks, nMismatch);
        if (nMismatch == 0 && nChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : printVerdict

    // watchdog against a hung sequence
    initial begin
        repeat (5000) @(posedge clock);
        nMismatch++;
        printVerdict();
    end

    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        @(negedge clock);
        `CHECK_EQ(hostInterruptPin_b, 1'b1);
        `CHECK_EQ(writePointer, POINTER_RESET);
        `CHECK_EQ(readPointer, POINTER_RESET);
        cpu_read(CONTROL_OFFSET, w);
        `CHECK_EQ(w, 32'h0000_0008);
        cpu_read(8'h3C, w);
        `CHECK_EQ(w, 32'h0000_0000);
        cpu_read(READ_POINTER_OFFSET, w);
        `CHECK_EQ(w, POINTER_RESET);
        // half order first, then single pointer mode host writes
        i_hpc_host_model.host_write(HPC_HOST_CONTROL, 1'b1, 16'h0001);
        cpu_read(CONTROL_OFFSET, w);
        `CHECK_EQ(w, 32'h0000_0109);
        i_hpc_host_model.host_write(HPC_HOST_POINTER, 1'b0, 16'h5678);
        i_hpc_host_model.host_write(HPC_HOST_POINTER, 1'b1, 16'h1234);
        @(negedge clock);
        `CHECK_EQ(writePointer, 32'h1234_5678);
        `CHECK_EQ(readPointer, 32'h1234_5678);
        i_hpc_host_model.host_read(HPC_HOST_POINTER, 1'b1, h);
        `CHECK_EQ(h, 16'h1234);
        i_hpc_host_model.host_read(HPC_HOST_CONTROL, 1'b1, h);
        `CHECK_EQ(h, 16'h0000);
        // split mode: select 0 reaches the write pointer, 1 the read pointer
        i_hpc_host_model.host_write(HPC_HOST_CONTROL, 1'b0, 16'h0201);
        i_hpc_host_model.host_write(HPC_HOST_POINTER, 1'b0, 16'h0001);
        i_hpc_host_model.host_write(HPC_HOST_POINTER, 1'b1, 16'hABCD);
        @(negedge clock);
        `CHECK_EQ(writePointer, 32'hABCD_0001);
        `CHECK_EQ(readPointer, 32'h1234_5678);
        i_hpc_host_model.host_write(HPC_HOST_CONTROL, 1'b0, 16'h0A01);
        i_hpc_host_model.host_write(HPC_HOST_POINTER, 1'b0, 16'hAAAA);
        i_hpc_host_model.host_write(HPC_HOST_POINTER, 1'b1, 16'h5555);
        @(negedge clock);
        `CHECK_EQ(readPointer, 32'h5555_AAAA);
        `CHECK_EQ(writePointer, 32'hABCD_0001);
        i_hpc_host_model.host_read(HPC_HOST_POINTER, 1'b0, h);
        `CHECK_EQ(h, 16'hAAAA);
        // back to upper halfword first
        i_hpc_host_model.host_write(HPC_HOST_CONTROL, 1'b0, 16'h0A00);
        cpu_read(CONTROL_OFFSET, w);
        `CHECK_EQ(w, 32'h0000_0A08);
        i_hpc_host_model.host_read(HPC_HOST_POINTER, 1'b0, h);
        `CHECK_EQ(h, 16'h5555);
        // pointer ownership
        cpu_write(WRITE_POINTER_OFFSET, 32'h1111_2222);
        @(negedge clock);
        `CHECK_EQ(writePointer, 32'hABCD_0001);
        @(posedge clock);
        pointerWriteOwner <= 1'b1;
        cpu_write(WRITE_POINTER_OFFSET, 32'h1111_2222);
        cpu_write(READ_POINTER_OFFSET, 32'h3333_4444);
        i_hpc_host_model.host_write(HPC_HOST_POINTER, 1'b1, 16'hDEAD);
        @(negedge clock);
        `CHECK_EQ(writePointer, 32'h1111_2222);
        `CHECK_EQ(readPointer, 32'h3333_4444);
        // control ownership
        cpu_write(CONTROL_OFFSET, 32'h0000_0001);
        @(negedge clock);
        `CHECK_EQ(halfOrder, 1'b0);
        @(posedge clock);
        controlWriteOwner <= 1'b1;
        cpu_write(CONTROL_OFFSET, 32'h0000_0201);
        @(negedge clock);
        `CHECK_EQ({splitPointerMode, pointerSelect, halfOrder}, 3'b101);
        i_hpc_host_model.host_write(HPC_HOST_CONTROL, 1'b0, 16'h0800);
        @(negedge clock);
        `CHECK_EQ(pointerSelect, 1'b0);
        @(posedge clock);
        pointerWriteOwner <= 1'b0;
        cpu_write(CONTROL_OFFSET, 32'h0000_0000);
        @(negedge clock);
        `CHECK_EQ(halfOrder, 1'b1);
        @(posedge clock);
        controlWriteOwner <= 1'b0;
        // host interrupt raised by processor, cleared by host
        cpu_write(CONTROL_OFFSET, 32'h0000_0004);
        @(negedge clock);
        `CHECK_EQ(hostInterruptPin_b, 1'b0);
        cpu_read(CONTROL_OFFSET, w);
        `CHECK_EQ(w, 32'h0000_030D);
        cpu_write(CONTROL_OFFSET, 32'h0000_0000);
        i_hpc_host_model.host_write(HPC_HOST_CONTROL, 1'b0, 16'h0201);
        @(negedge clock);
        `CHECK_EQ(hostInterruptPin_b, 1'b0);
        i_hpc_host_model.host_write(HPC_HOST_CONTROL, 1'b0, 16'h0205);
        @(negedge clock);
        `CHECK_EQ(hostInterruptPin_b, 1'b1);
        i_hpc_host_model.host_read(HPC_HOST_CONTROL, 1'b0, h);
        `CHECK_EQ(h, 16'h0309);
        // processor interrupt from the host
        i_hpc_host_model.host_write(HPC_HOST_CONTROL, 1'b0, 16'h0203);
        cpu_read(CONTROL_OFFSET, w);
        `CHECK_EQ(w, 32'h0000_030B);
        i_hpc_host_model.host_write(HPC_HOST_CONTROL, 1'b0, 16'h0201);
        cpu_write(CONTROL_OFFSET, 32'h0000_0000);
        @(negedge clock);
        `CHECK_EQ(processorInterruptRequest, 1'b1);
        cpu_write(CONTROL_OFFSET, 32'h0000_0002);
        @(negedge clock);
        `CHECK_EQ(processorInterruptRequest, 1'b0);
        // prefetch request from the host only, bit always reads zero
        i_hpc_host_model.host_write(HPC_HOST_CONTROL, 1'b0, 16'h0211);
        @(negedge clock);
        `CHECK_EQ(prefetchRequest, 1'b1);
        @(negedge clock);
        `CHECK_EQ(prefetchRequest, 1'b0);
        i_hpc_host_model.host_read(HPC_HOST_CONTROL, 1'b0, h);
        `CHECK_EQ(h, 16'h0309);
        cpu_write(CONTROL_OFFSET, 32'h0000_0010);
        @(negedge clock);
        `CHECK_EQ(prefetchRequest, 1'b0);
        cpu_read(CONTROL_OFFSET, w);
        `CHECK_EQ(w, 32'h0000_0309);
        // soft reset set by the non-owner processor, cleared by the owning host
        cpu_write(CONTROL_OFFSET, 32'h0000_0080);
        @(negedge clock);
        `CHECK_EQ(portSoftReset, 1'b1);
        i_hpc_host_model.host_write(HPC_HOST_CONTROL, 1'b0, 16'h0201);
        @(negedge clock);
        `CHECK_EQ(portSoftReset, 1'b0);
        printVerdict();
    end

endmodule : hpc_control_pointers_tb
